// ---- include/smartcard_consts.vh ----
// Offsets, field positions, reset values and timing points of the card interface
`ifndef SMARTCARD_CONSTS_VH
`define SMARTCARD_CONSTS_VH

// ****************************************
// Register offsets (20-bit address)
// ****************************************
`define OFS_MODE_CFG       20'hFFFB0
`define OFS_BIT_RATE_DIV   20'hFFFB1
`define OFS_CONTROL        20'hFFFB2
`define OFS_TX_DATA        20'hFFFB3
`define OFS_STATUS         20'hFFFB4
`define OFS_RX_DATA        20'hFFFB5
`define OFS_CARD_MODE      20'hFFFB6

// ****************************************
// Field positions
// ****************************************
`define MODE_ALT_TIMING    7
`define MODE_ODD_PARITY    4
`define MODE_PRESC_HI      1
`define MODE_PRESC_LO      0
`define CTRL_TX_ENABLE     5
`define CTRL_RX_ENABLE     4
`define CTRL_CLK_MODE_HI   1
`define CTRL_CLK_MODE_LO   0
`define STAT_TX_EMPTY      7
`define STAT_RX_FULL       6
`define STAT_OVERRUN       5
`define STAT_ERR_SIGNAL    4
`define STAT_PARITY_ERR    3
`define STAT_TX_END        2
`define CARD_BIT_ORDER     3
`define CARD_DATA_INVERT   2
`define CARD_ENABLE        0

// ****************************************
// Reset values
// ****************************************
`define CFG_RESET          8'h00
`define STATUS_RESET       8'h84

// ****************************************
// Timing: sub-ticks per half etu, then points in half etu from the start edge
// ****************************************
`define HALF_ETU_SUBTICKS  9'h174
`define PT_START_CHECK     5'h01
`define PT_PARITY_END      5'h14
`define PT_PARITY_SAMPLE   5'h13
`define PT_ERR_DRIVE       5'h15
`define PT_ERR_SAMPLE      5'h16
`define PT_ERR_RELEASE     5'h17
`define PT_TRANSMIT_END_FLAG_ALT        5'h16
`define PT_TRANSMIT_END_FLAG_NORMAL     5'h19
`define PT_TX_FINISH       5'h1B

`endif

// ---- core/etu_timebase.v ----
// Baud-rate generator: sub-tick of the card clock and half-etu tick
`timescale 1ns/100ps
`default_nettype none
`include "smartcard_consts.vh"

module etu_timebase (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       ce,
	input  wire       sync,
	input  wire [1:0] presc,
	input  wire [7:0] divisor,
	output reg        sub_tick,
	output reg        half_tick
);

	reg  [5:0] pre_q;
	reg  [7:0] div_q;
	reg  [8:0] half_q;
	reg  [5:0] pre_lim;
	reg  [5:0] pre_b;
	reg  [7:0] div_b;
	reg  [8:0] half_b;

	// Prescaler limit: divide by 4 to the power n
	always @* begin
		case (presc)
			2'h0:    pre_lim = 6'h00;
			2'h1:    pre_lim = 6'h03;
			2'h2:    pre_lim = 6'h0F;
			default: pre_lim = 6'h3F;
		endcase
	end

	// Restart counts as the first clock, so the first half etu is as long as the rest
	always @* begin
		pre_b  = sync ? 6'h00 : pre_q;
		div_b  = sync ? 8'h00 : div_q;
		half_b = sync ? 9'h000 : half_q;
	end

	// Sub-tick every 4^n*(N+1) clocks, half etu every 372 sub-ticks
	always @(posedge clk) begin
		if (!rst_n) begin
			pre_q     <= 6'h00;
			div_q     <= 8'h00;
			half_q    <= 9'h000;
			sub_tick  <= 1'b0;
			half_tick <= 1'b0;
		end else if (ce) begin
			sub_tick  <= 1'b0;
			half_tick <= 1'b0;
			if (pre_b == pre_lim) begin
				pre_q <= 6'h00;
				if (div_b == divisor) begin
					div_q    <= 8'h00;
					sub_tick <= 1'b1;
					if (half_b == `HALF_ETU_SUBTICKS - 9'h001) begin
						half_q    <= 9'h000;
						half_tick <= 1'b1;
					end else begin
						half_q <= half_b + 9'h001;
					end
				end else begin
					div_q  <= div_b + 8'h01;
					half_q <= half_b;
				end
			end else begin
				pre_q  <= pre_b + 6'h01;
				div_q  <= div_b;
				half_q <= half_b;
			end
		end
	end

endmodule // etu_timebase
`default_nettype wire

// ---- core/smartcard_if.v ----
// Half-duplex smart card serial interface with register port
//
// What this block does
// - Frame is start, eight data, one parity.
// - Transmit guard of at least two etu.
// - Parity error drives low at 10.5 etu.
// - Error seen: resend same frame after 2 etu.
// - Asynchronous framing only, no synchronous mode.
// - Release line after parity; pull-up holds idle.
// - Release line after error signal ends.
// - No error signal: proceed to next frame.
// - Transmit and receive together give closed loopback.
// - Timing-mode bit selects normal or alternative.
// - Card mode enable activates the interface.
// - Clock mode 00 off in normal timing, 01 runs card clock.
// - Direct convention: plain levels, LSB first.
// - Parity is even over eight data bits.
// - Alternative mode: fixed low, fixed high, running.
// - Invert touches data only; parity via odd.
// - Transmit end at 12.5 or 11.0 etu.
// - Error-signal flag set on sampled low.
//
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "smartcard_consts.vh"

module smartcard_if (
	input  wire        CLK,
	input  wire        RST_N,
	input  wire        CE,
	input  wire [19:0] ADDR,
	input  wire [7:0]  WR_DATA,
	input  wire        WR_STB,
	input  wire        RD_STB,
	output reg  [7:0]  RD_DATA,
	input  wire        DATA_IN,
	output reg         DATA_OUT,
	output reg         DATA_OE,
	output reg         SCK_OUT,
	output reg         SCK_OE
);

	// ****************************************
	// Conversion helper
	// ****************************************

	// Order then invert; the same mapping serves encode and decode
	function [7:0] conv;
		input [7:0] d;
		input       msb_first;
		input       invert;
		integer     k;
		begin
			for (k = 0; k < 8; k = k + 1)
				conv[k] = (msb_first ? d[7 - k] : d[k]) ^ invert;
		end
	endfunction

	// ****************************************
	// Registers and state
	// ****************************************
	reg  [7:0] serial_mode_cfg_q;
	reg  [7:0] bit_rate_divisor_q;
	reg  [7:0] serial_control_q;
	reg  [7:0] transmit_data_buffer_q;
	reg  [7:0] receive_data_buffer_q;
	reg  [7:0] card_mode_cfg_q;
	reg        tx_buffer_empty_q;
	reg        rx_buffer_full_q;
	reg        overrun_flag_q;
	reg        error_signal_flag_q;
	reg        parity_error_flag_q;
	reg        transmit_end_flag_q;
	reg        tx_busy_q;
	reg  [4:0] tx_half_q;
	reg  [9:0] tx_frame_q;
	reg        tx_err_q;
	reg        tx_drive_q;
	reg        rx_busy_q;
	reg  [4:0] rx_half_q;
	reg  [8:0] rx_shift_q;
	reg        rx_drive_q;
	reg        line_prev_q;
	reg        card_clk_q;
	wire [2:0] tb_sync;
	wire [2:0] tb_sub;
	wire [2:0] tb_half;

	// Field decode
	wire       card_mode_enable   = card_mode_cfg_q[`CARD_ENABLE];
	wire       bit_order_select   = card_mode_cfg_q[`CARD_BIT_ORDER];
	wire       data_invert_select = card_mode_cfg_q[`CARD_DATA_INVERT];
	wire       alt_timing_mode    = serial_mode_cfg_q[`MODE_ALT_TIMING];
	wire       odd_parity         = serial_mode_cfg_q[`MODE_ODD_PARITY];
	wire       transmitter_enable = serial_control_q[`CTRL_TX_ENABLE];
	wire       receiver_enable    = serial_control_q[`CTRL_RX_ENABLE];
	wire       clock_pin_mode_hi  = serial_control_q[`CTRL_CLK_MODE_HI];
	wire       clock_pin_mode_lo  = serial_control_q[`CTRL_CLK_MODE_LO];
	wire [7:0] status_rst         = `STATUS_RESET;

	// loopback via line
	// The receiver sees the pin and our own drive, so TX and RX enabled together close a loop
	wire       line_seen = DATA_IN & ~DATA_OE;

	// Bus strobes
	wire       wr_status = WR_STB && (ADDR == `OFS_STATUS);

	// Transmit timing points, one cycle before the half count reaches them
	wire       tx_tick   = tb_half[0];
	wire [4:0] transmit_end_flag_pt   = alt_timing_mode ? `PT_TRANSMIT_END_FLAG_ALT : `PT_TRANSMIT_END_FLAG_NORMAL;
	wire       tx_load   = !tx_busy_q && card_mode_enable && transmitter_enable && !tx_buffer_empty_q;
	wire       err_now   = tx_busy_q && tx_tick && (tx_half_q == `PT_ERR_SAMPLE - 5'h01) && !line_seen;

	// Receive timing
	wire       rx_tick   = tb_half[1];
	wire [4:0] rx_next   = rx_half_q + 5'h01;
	wire       rx_start  = !rx_busy_q && card_mode_enable && receiver_enable && line_prev_q && !line_seen;

	// even parity check
	// Odd select flips the expected sum; an error is a nonzero remainder
	wire       rx_par_bad = (^rx_shift_q) ^ odd_parity;

	// ****************************************
	// Rate generators
	// ****************************************

	// etu from rate generator
	// Unit 0 times transmit, unit 1 receive, unit 2 runs the card clock freely
	assign tb_sync = {1'b0, rx_start, tx_load};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_tb
			etu_timebase u_tb (
				.clk      (CLK),
				.rst_n    (RST_N),
				.ce       (CE),
				.sync     (tb_sync[gi]),
				.presc    (serial_mode_cfg_q[`MODE_PRESC_HI:`MODE_PRESC_LO]),
				.divisor  (bit_rate_divisor_q),
				.sub_tick (tb_sub[gi]),
				.half_tick(tb_half[gi])
			);
		end
	endgenerate

	// ****************************************
	// Configuration registers
	// ****************************************

	// no synchronous mode
	// Mode bit 7 only selects the timing mode; no clocked-serial path exists
	always @(posedge CLK) begin
		if (!RST_N) begin
			serial_mode_cfg_q      <= `CFG_RESET;
			bit_rate_divisor_q     <= 8'hFF;
			serial_control_q       <= `CFG_RESET;
			transmit_data_buffer_q <= `CFG_RESET;
			card_mode_cfg_q        <= `CFG_RESET;
		end else if (CE && WR_STB) begin
			case (ADDR)
				`OFS_MODE_CFG:     serial_mode_cfg_q      <= WR_DATA;
				`OFS_BIT_RATE_DIV: bit_rate_divisor_q     <= WR_DATA;
				`OFS_CONTROL:      serial_control_q       <= WR_DATA;
				`OFS_TX_DATA:      transmit_data_buffer_q <= WR_DATA;
				`OFS_CARD_MODE:    card_mode_cfg_q        <= WR_DATA & 8'h0D;
				default:           ;
			endcase
		end
	end

	// Read data one cycle after the strobe, zero for unmapped
	always @(posedge CLK) begin
		if (!RST_N) begin
			RD_DATA <= 8'h00;
		end else if (CE) begin
			RD_DATA <= 8'h00;
			if (RD_STB) begin
				case (ADDR)
					`OFS_MODE_CFG:     RD_DATA <= serial_mode_cfg_q;
					`OFS_BIT_RATE_DIV: RD_DATA <= bit_rate_divisor_q;
					`OFS_CONTROL:      RD_DATA <= serial_control_q;
					`OFS_TX_DATA:      RD_DATA <= transmit_data_buffer_q;
					`OFS_STATUS:       RD_DATA <= {tx_buffer_empty_q, rx_buffer_full_q, overrun_flag_q,
						error_signal_flag_q, parity_error_flag_q, transmit_end_flag_q, 2'h0};
					`OFS_RX_DATA:      RD_DATA <= receive_data_buffer_q;
					`OFS_CARD_MODE:    RD_DATA <= card_mode_cfg_q;
					default:           RD_DATA <= 8'h00;
				endcase
			end
		end
	end

	// ****************************************
	// Transmitter
	// ****************************************

	// Frame sequencer in half etu; flags clear on a written zero, hardware set wins
	always @(posedge CLK) begin
		if (!RST_N) begin
			tx_busy_q           <= 1'b0;
			tx_half_q           <= 5'h00;
			tx_frame_q          <= 10'h3FF;
			tx_err_q            <= 1'b0;
			tx_buffer_empty_q   <= status_rst[`STAT_TX_EMPTY];
			transmit_end_flag_q <= status_rst[`STAT_TX_END];
			error_signal_flag_q <= 1'b0;
		end else if (CE) begin
			if (wr_status && !WR_DATA[`STAT_TX_EMPTY]) begin
				tx_buffer_empty_q   <= 1'b0;
				transmit_end_flag_q <= 1'b0;
			end
			if (wr_status && !WR_DATA[`STAT_ERR_SIGNAL])
				error_signal_flag_q <= 1'b0;
			if (tx_load) begin
				tx_frame_q <= {(^transmit_data_buffer_q) ^ odd_parity,
					conv(transmit_data_buffer_q, bit_order_select, data_invert_select), 1'b0};
				tx_buffer_empty_q <= 1'b1;
				tx_busy_q         <= 1'b1;
				tx_half_q         <= 5'h00;
				tx_err_q          <= 1'b0;
			end else if (tx_busy_q && !transmitter_enable) begin
				tx_busy_q <= 1'b0;
			end else if (tx_busy_q && tx_tick) begin
				tx_half_q <= tx_half_q + 5'h01;
				if (err_now) begin
					error_signal_flag_q <= 1'b1;
					tx_err_q            <= 1'b1;
				end
				if ((tx_half_q == transmit_end_flag_pt - 5'h01) && tx_buffer_empty_q && !tx_err_q && !error_signal_flag_q && !err_now)
					transmit_end_flag_q <= 1'b1;
				if (tx_half_q == `PT_TX_FINISH - 5'h01) begin
					if (tx_err_q) begin
						tx_half_q <= 5'h00;
						tx_err_q  <= 1'b0;
					end else begin
						tx_busy_q <= 1'b0;
					end
				end
			end
		end
	end

	// drive only start/data/parity lows
	// Line is released from the end of the parity bit on
	always @(posedge CLK) begin
		if (!RST_N)
			tx_drive_q <= 1'b0;
		else if (CE)
			tx_drive_q <= tx_busy_q && (tx_half_q < `PT_PARITY_END) && !tx_frame_q[tx_half_q[4:1]];
	end

	// ****************************************
	// Receiver
	// ****************************************

	// Samples mid-bit, checks parity, answers errors with a low pulse
	always @(posedge CLK) begin
		if (!RST_N) begin
			rx_busy_q             <= 1'b0;
			rx_half_q             <= 5'h00;
			rx_shift_q            <= 9'h000;
			rx_drive_q            <= 1'b0;
			line_prev_q           <= 1'b1;
			receive_data_buffer_q <= 8'h00;
			rx_buffer_full_q      <= 1'b0;
			overrun_flag_q        <= 1'b0;
			parity_error_flag_q   <= 1'b0;
		end else if (CE) begin
			line_prev_q <= line_seen;
			if (wr_status && !WR_DATA[`STAT_RX_FULL])
				rx_buffer_full_q <= 1'b0;
			if (wr_status && !WR_DATA[`STAT_OVERRUN])
				overrun_flag_q <= 1'b0;
			if (wr_status && !WR_DATA[`STAT_PARITY_ERR])
				parity_error_flag_q <= 1'b0;
			if (rx_start) begin
				rx_busy_q <= 1'b1;
				rx_half_q <= 5'h00;
			end else if (rx_busy_q && !receiver_enable) begin
				rx_busy_q  <= 1'b0;
				rx_drive_q <= 1'b0;
			end else if (rx_busy_q && rx_tick) begin
				rx_half_q <= rx_next;
				if (rx_next == `PT_START_CHECK && line_seen) begin
					rx_busy_q <= 1'b0;
				end else if (rx_next[0] && rx_next > `PT_START_CHECK && rx_next <= `PT_PARITY_SAMPLE) begin
					rx_shift_q <= {line_seen, rx_shift_q[8:1]};
				end else if (rx_next == `PT_ERR_DRIVE) begin
					if (rx_par_bad) begin
						rx_drive_q          <= 1'b1;
						parity_error_flag_q <= 1'b1;
					end else if (rx_buffer_full_q) begin
						overrun_flag_q <= 1'b1;
					end else begin
						receive_data_buffer_q <= conv(rx_shift_q[7:0], bit_order_select, data_invert_select);
						rx_buffer_full_q      <= 1'b1;
					end
				end else if (rx_next == `PT_ERR_RELEASE) begin
					rx_drive_q <= 1'b0;
					rx_busy_q  <= 1'b0;
				end
			end
		end
	end

	// ****************************************
	// Pins
	// ****************************************

	// Open-drain data pin and card clock pin
	always @(posedge CLK) begin
		if (!RST_N) begin
			DATA_OUT   <= 1'b0;
			DATA_OE    <= 1'b0;
			card_clk_q <= 1'b0;
			SCK_OUT    <= 1'b0;
			SCK_OE     <= 1'b0;
		end else if (CE) begin
			DATA_OUT <= 1'b0;
			DATA_OE  <= card_mode_enable && (tx_drive_q || rx_drive_q);
			if (tb_sub[2])
				card_clk_q <= ~card_clk_q;
			SCK_OE  <= card_mode_enable && (alt_timing_mode || clock_pin_mode_lo);
			SCK_OUT <= card_mode_enable && (clock_pin_mode_lo ? card_clk_q : (alt_timing_mode && clock_pin_mode_hi));
		end
	end

endmodule // smartcard_if
`default_nettype wire

// ---- testbench/smartcard_if_sva.sv ----
// Port checker for the card interface
`timescale 1ns/100ps
`default_nettype none
`include "smartcard_consts.vh"
// ********
// Checker
// ********
module smartcard_if_sva (
	input wire logic        CLK,
	input wire logic        RST_N,
	input wire logic        CE,
	input wire logic [19:0] ADDR,
	input wire logic [7:0]  WR_DATA,
	input wire logic        WR_STB,
	input wire logic        RD_STB,
	input wire logic [7:0]  RD_DATA,
	input wire logic        DATA_IN,
	input wire logic        DATA_OUT,
	input wire logic        DATA_OE,
	input wire logic        SCK_OUT,
	input wire logic        SCK_OE
);
	localparam int ETU = 744;
	logic [3:0]  cfg_q;
	logic [15:0] run_q;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// Shadow of alt mode, clock mode and card enable
	always_ff @(posedge CLK) begin
		if (!RST_N) cfg_q <= 4'h0;
		else if (WR_STB && CE && ADDR == `OFS_MODE_CFG) cfg_q[3] <= WR_DATA[7];
		else if (WR_STB && CE && ADDR == `OFS_CONTROL) cfg_q[2:1] <= WR_DATA[1:0];
		else if (WR_STB && CE && ADDR == `OFS_CARD_MODE) cfg_q[0] <= WR_DATA[0];
	end
	// Length of each low drive
	always_ff @(posedge CLK) begin
		if (!RST_N || !DATA_OE) run_q <= 16'h0000;
		else run_q <= run_q + 16'h0001;
	end
	sequence s_cfg; cfg_q == $past(cfg_q) && cfg_q == $past(cfg_q, 2); endsequence
	// Read data only in its cycle
	property p_rd_idle; !$past(RD_STB) |-> RD_DATA == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
	property p_out_low; DATA_OUT == 1'b0; endproperty
	a_out_low: assert property (p_out_low) else $error("line driven high");
	property p_oe_len; $fell(DATA_OE) |-> run_q % ETU == 0; endproperty
	a_oe_len: assert property (p_oe_len) else $error("drive not whole etu");
	// Reset clears outputs
	property p_rst; disable iff (1'b0) !RST_N |=> RD_DATA == 8'h00 && !DATA_OE && !SCK_OE; endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
	property p_sck_oe; s_cfg |-> SCK_OE == (cfg_q[0] && (cfg_q[3] || cfg_q[1])); endproperty
	a_sck_oe: assert property (p_sck_oe) else $error("clock pin enable wrong");
	property p_sck_fix; s_cfg ##0 (cfg_q ==? 4'b1?01) |-> SCK_OUT == cfg_q[2]; endproperty
	a_sck_fix: assert property (p_sck_fix) else $error("fixed clock level wrong");
	property p_sck_run; s_cfg ##0 (cfg_q[1:0] == 2'b11) |-> SCK_OUT != $past(SCK_OUT); endproperty
	a_sck_run: assert property (p_sck_run) else $error("card clock not running");
	property p_card_off; s_cfg ##0 !cfg_q[0] |-> !DATA_OE && !SCK_OE; endproperty
	a_card_off: assert property (p_card_off) else $error("active with card mode off");
	c_one_etu: cover property ($fell(DATA_OE) && run_q == 16'h02E8);
	c_fixed: cover property (s_cfg ##0 (cfg_q ==? 4'b1?01));
	c_read: cover property (RD_STB ##1 RD_DATA != 8'h00);
endmodule // smartcard_if_sva
bind smartcard_if smartcard_if_sva u_smartcard_if_sva (.CLK, .RST_N, .CE, .ADDR, .WR_DATA, .WR_STB, .RD_STB,
	.RD_DATA, .DATA_IN, .DATA_OUT, .DATA_OE, .SCK_OUT, .SCK_OE);
`default_nettype wire

// ---- testbench/card_model.sv ----
// Behavioural smart card on the pulled-up data line
`timescale 1ns/100ps
`default_nettype none
// ********
// Card
// ********
module card_model #(
	parameter int ETU = 744
) (
	input  wire logic       clk,
	input  wire logic       line,
	input  wire logic       nack_en,
	input  wire logic       send,
	input  wire logic [8:0] tx_bits,
	output logic            pull,
	output logic [8:0]      rx_bits,
	output int              rx_cnt,
	output logic            nack_seen
);
	logic nack_q;
	// Send own frames or take device frames
	initial begin
		pull = 1'b0;
		rx_cnt = 0;
		nack_seen = 1'b0;
		nack_q = 1'b0;
		rx_bits = 9'h000;
		forever begin
			@(posedge clk);
			if (send) begin
				for (int i = 0; i < 10; i++) begin
					pull <= (i == 0) ? 1'b1 : !tx_bits[i - 1];
					repeat (ETU) @(posedge clk);
				end
				pull <= 1'b0;
				repeat (ETU) @(posedge clk);
				nack_seen <= !line;
				repeat (2 * ETU) @(posedge clk);
			end else if (!line) begin
				nack_q = nack_en;
				repeat (ETU / 2) @(posedge clk);
				for (int i = 0; i < 9; i++) begin
					repeat (ETU) @(posedge clk);
					rx_bits[i] <= line;
				end
				rx_cnt <= rx_cnt + 1;
				repeat (ETU) @(posedge clk);
				if (nack_q) begin
					pull <= 1'b1;
					repeat (ETU) @(posedge clk);
					pull <= 1'b0;
				end
			end
		end
	end
endmodule // card_model
`default_nettype wire

// ---- testbench/smartcard_if_tb.sv ----
// Self-checking bench of the card interface
`timescale 1ns/100ps
`default_nettype none
`include "smartcard_consts.vh"
// ********
// Bench
// ********
module smartcard_if_tb;
	localparam int FR = 10044;
	logic        CLK = 1'b0;
	logic        RST_N = 1'b0;
	logic [19:0] ADDR = 20'h00000;
	logic [7:0]  WR_DATA = 8'h00;
	logic        WR_STB = 1'b0;
	logic        RD_STB = 1'b0;
	logic        CE = 1'b1;
	logic        nack = 1'b0;
	logic        send = 1'b0;
	logic [8:0]  bits = 9'h000;
	wire logic [7:0] RD_DATA;
	wire logic   DATA_OUT, DATA_OE, SCK_OUT, SCK_OE, pull, nack_seen;
	wire logic [8:0] rx_bits;
	wire logic   line = !(DATA_OE === 1'b1 || pull);
	int          rx_cnt;
	int          failures = 0;
	int          tests_run = 0;
	smartcard_if u_smartcard_if (.CLK, .RST_N, .CE, .ADDR, .WR_DATA, .WR_STB, .RD_STB, .RD_DATA,
		.DATA_IN(line), .DATA_OUT, .DATA_OE, .SCK_OUT, .SCK_OE);
	card_model u_card_model (.clk(CLK), .line, .nack_en(nack), .send, .tx_bits(bits), .pull, .rx_bits,
		.rx_cnt, .nack_seen);
	// Clock of 50 ns
	initial forever #25 CLK = !CLK;
	task automatic wt(input int n);
		repeat (n) @(posedge CLK);
	endtask
	task automatic chk(input string n, input logic [8:0] e, input logic [8:0] s);
		tests_run++;
		if (s !== e) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [19:0] a, input logic [7:0] d);
		ADDR <= a;
		WR_DATA <= d;
		WR_STB <= 1'b1;
		wt(1);
		WR_STB <= 1'b0;
		wt(1);
	endtask
	task automatic rd(input logic [19:0] a, input logic [7:0] e);
		ADDR <= a;
		RD_STB <= 1'b1;
		wt(1);
		RD_STB <= 1'b0;
		#1 chk($sformatf("register %h", a), {1'b0, e}, {1'b0, RD_DATA});
		wt(1);
	endtask
	// Line levels of data then parity
	function automatic logic [8:0] frame(input logic [7:0] d, input logic inv);
		logic [7:0] l;
		for (int i = 0; i < 8; i++) l[i] = inv ? !d[7 - i] : d[i];
		return {^l ^ inv, l};
	endfunction
	task automatic ld(input logic [7:0] d);
		wr(`OFS_TX_DATA, d);
		wr(`OFS_STATUS, 8'h7F);
	endtask
	// Status just before and after transmit end
	task automatic tx(input int p, input logic [7:0] st);
		wt(p - 40);
		rd(`OFS_STATUS, st);
		wt(76);
		rd(`OFS_STATUS, st | 8'h04);
		wt(FR - p);
	endtask
	task automatic rx(input logic [8:0] b);
		bits <= b;
		send <= 1'b1;
		wt(1);
		send <= 1'b0;
		wt(FR);
	endtask
	task automatic stop_test;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Watchdog
	initial begin
		wt(90000);
		failures++;
		$display("unexpected watchdog: expected end seen hang");
		stop_test;
	end
	// Main sequence
	initial begin
		wt(3);
		RST_N <= 1'b1;
		wt(1);
		rd(`OFS_STATUS, 8'h84);
		rd(`OFS_MODE_CFG, 8'h00);
		rd(`OFS_BIT_RATE_DIV, 8'hFF);
		rd(20'hFFFB7, 8'h00);
		wr(`OFS_CARD_MODE, 8'hFF);
		rd(`OFS_CARD_MODE, 8'h0D);
		wr(`OFS_CARD_MODE, 8'h00);
		wr(`OFS_RX_DATA, 8'h55);
		rd(`OFS_RX_DATA, 8'h00);
		wr(`OFS_BIT_RATE_DIV, 8'h00);
		rd(`OFS_BIT_RATE_DIV, 8'h00);
		CE <= 1'b0;
		wr(`OFS_BIT_RATE_DIV, 8'h12);
		CE <= 1'b1;
		rd(`OFS_BIT_RATE_DIV, 8'h00);
		wr(`OFS_MODE_CFG, 8'h28);
		wt(744);
		wr(`OFS_CONTROL, 8'h31);
		ld(8'h3B);
		wt(1500);
		rd(`OFS_STATUS, 8'h00);
		chk("card frames", 9'h000, 9'(rx_cnt));
		wr(`OFS_CARD_MODE, 8'h01);
		tx(9300, 8'hC0);
		rd(`OFS_RX_DATA, 8'h3B);
		chk("card bits", frame(8'h3B, 1'b0), rx_bits);
		chk("card frames", 9'h001, 9'(rx_cnt));
		wr(`OFS_STATUS, 8'hBF);
		wr(`OFS_CONTROL, 8'h21);
		nack <= 1'b1;
		ld(8'hA5);
		wt(100);
		nack <= 1'b0;
		wt(9500);
		chk("idle line", 9'h001, {8'h00, line});
		wt(10600);
		rd(`OFS_STATUS, 8'h90);
		chk("card bits", frame(8'hA5, 1'b0), rx_bits);
		chk("card frames", 9'h003, 9'(rx_cnt));
		wr(`OFS_STATUS, 8'hEF);
		wr(`OFS_MODE_CFG, 8'hB8);
		wr(`OFS_CARD_MODE, 8'h0D);
		wr(`OFS_CONTROL, 8'h22);
		ld(8'h3F);
		tx(8184, 8'h80);
		chk("card bits", frame(8'h3F, 1'b1), rx_bits);
		chk("card frames", 9'h004, 9'(rx_cnt));
		wr(`OFS_CONTROL, 8'h20);
		wt(10);
		wr(`OFS_MODE_CFG, 8'h28);
		wr(`OFS_CARD_MODE, 8'h01);
		wr(`OFS_CONTROL, 8'h11);
		wt(744);
		rx(frame(8'h5A, 1'b0));
		rd(`OFS_STATUS, 8'hC4);
		rd(`OFS_RX_DATA, 8'h5A);
		chk("error signal", 9'h000, {8'h00, nack_seen});
		rx(frame(8'hC3, 1'b0) ^ 9'h100);
		chk("error signal", 9'h001, {8'h00, nack_seen});
		rd(`OFS_STATUS, 8'hCC);
		rx(frame(8'h66, 1'b0));
		chk("error signal", 9'h000, {8'h00, nack_seen});
		rd(`OFS_STATUS, 8'hEC);
		rd(`OFS_RX_DATA, 8'h5A);
		RST_N <= 1'b0;
		wt(3);
		RST_N <= 1'b1;
		wt(1);
		rd(`OFS_STATUS, 8'h84);
		rd(`OFS_CONTROL, 8'h00);
		stop_test;
	end
endmodule // smartcard_if_tb
`default_nettype wire
